// ---- rtl/cwd_pkg.sv ----
/*
 Constants for the configuration word decoder: register offsets,
 field positions, codes and the erased values of both words.
 Assumes a single 25 MHz clock domain and an AHB-Lite register bus.
*/
package cwd_pkg;
	// Register byte offsets
	localparam logic [7:0] CWD_OFS_CFG0 = 8'h00;
	localparam logic [7:0] CWD_OFS_CFG1 = 8'h04;
	localparam logic [7:0] CWD_OFS_CTRL = 8'h08;
	localparam logic [7:0] CWD_OFS_STAT = 8'h0C;
	// Protection and debug word fields
	localparam int CWD_CP_BIT  = 28;
	localparam int CWD_BWP_BIT = 24;
	localparam int CWD_PWP_HI  = 18;
	localparam int CWD_PWP_LO  = 10;
	localparam int CWD_DPS_HI  = 4;
	localparam int CWD_DPS_LO  = 3;
	localparam int CWD_BSE_BIT = 2;
	localparam int CWD_DBG_HI  = 1;
	localparam int CWD_DBG_LO  = 0;
	// Watchdog and clock word fields
	localparam int CWD_WWS_HI  = 25;
	localparam int CWD_WWS_LO  = 24;
	localparam int CWD_WFE_BIT = 23;
	localparam int CWD_WWD_BIT = 22;
	localparam int CWD_WPS_HI  = 20;
	localparam int CWD_WPS_LO  = 16;
	localparam int CWD_CSM_HI  = 15;
	localparam int CWD_CSM_LO  = 14;
	localparam int CWD_PBD_HI  = 13;
	localparam int CWD_PBD_LO  = 12;
	localparam int CWD_POM_HI  = 9;
	localparam int CWD_POM_LO  = 8;
	localparam int CWD_OSC_HI  = 2;
	localparam int CWD_OSC_LO  = 0;
	// Program write protect arithmetic
	localparam int         CWD_ADDR_W   = 19;
	localparam logic [8:0] CWD_PWP_NONE = 9'h1FF;
	localparam logic [8:0] CWD_PWP_ALL  = 9'h000;
	localparam logic [9:0] CWD_PAGE_LOW = 10'h000;
	localparam logic [1:0] CWD_PWP_TOP1 = 2'h3;
	// Codes
	localparam logic [4:0]  CWD_WPS_MAX  = 5'h14;
	localparam logic [20:0] CWD_WPS_ONE  = 21'h000001;
	localparam logic [3:0]  CWD_PBD_ONE  = 4'h1;
	localparam logic [1:0]  CWD_DBG_OFF  = 2'h3;
	localparam logic [1:0]  CWD_POM_OFF  = 2'h3;
	localparam logic [1:0]  CWD_CSM_BOTH = 2'h0;
	// Window size in eighths of the period
	localparam logic [2:0] CWD_WIN_25  = 3'h2;
	localparam logic [2:0] CWD_WIN_375 = 3'h3;
	localparam logic [2:0] CWD_WIN_50  = 3'h4;
	localparam logic [2:0] CWD_WIN_75  = 3'h6;
	// Runtime control register bits
	localparam int CWD_CTRL_WDT = 0;
	localparam int CWD_CTRL_BSE = 3;
	// Status register bits
	localparam int CWD_STAT_LOADED = 0;
	localparam int CWD_STAT_CP     = 1;
	localparam int CWD_STAT_WDT    = 2;
	localparam int CWD_STAT_CONFL  = 3;
	// Erased storage values, bit 31 of word 0 reserved low
	localparam logic [31:0] CWD_CFG0_ERASED = 32'h7FFF_FFFF;
	localparam logic [31:0] CWD_CFG1_ERASED = 32'hFFFF_FFFF;
	localparam logic [31:0] CWD_ZERO        = 32'h0000_0000;
	// Reset clock sources
	typedef enum logic [2:0] {
		CWD_OSC_FRC      = 3'h0,
		CWD_OSC_FRC_PLL  = 3'h1,
		CWD_OSC_PRI      = 3'h2,
		CWD_OSC_PRI_PLL  = 3'h3,
		CWD_OSC_SEC      = 3'h4,
		CWD_OSC_LPRC     = 3'h5,
		CWD_OSC_FRC_D16  = 3'h6,
		CWD_OSC_FRC_DIV  = 3'h7
	} cwd_osc_t;
endpackage

// ---- rtl/cwd_config_word_decoder.sv ----
/*
 Configuration word decoder: captures both nonvolatile configuration
 words after power-on reset and decodes protection, debug, watchdog
 and clock fields. An AHB-Lite slave exposes the words read-only plus
 a small runtime control and status pair.
 Decoded outputs other than boundary_scan_enable, watchdog_run and
 prog_write_blocked are levels taken from the captured copies, so
 they stand unchanged from the load edge until the next reset.
 Assumes nv_word0/nv_word1 are stable from power-on and that hready
 is the hreadyout of this sole slave. Storage is read only once: a
 programmer that changes the words must reset the block afterwards.
*/
// Local design decisions: the register addresses and the AHB-Lite register port.
// Summary of operation
// - Code protect low refuses external programmer access
// - Boot write protect low blocks boot writes
// - Program protect all ones none, zeros all
// - Protect below (511 minus field) times 0x400
// - Top two protect bits only on large flash
// - Debug pin pair chosen by two-bit field
// - Boundary-scan bit seeds runtime enable bit
// - Debugger enabled at 0x, forced off when protected
// - Window size 25, 37.5, 50, 75 percent
// - Forced watchdog runs, software cannot disable
// - Window disable bit selects non-window mode
// - Postscale ratio one to two power field
// - Postscale above 10100 behaves as 10100
// - Oscillator select field picks reset clock source
// - Primary mode field: off, HS, XT, external
// - Peripheral divisor 8, 4, 2 or 1
// - Clock switch and fail-safe monitor selection
module cwd_config_word_decoder
	import cwd_pkg::*;
#(
	// Variant options: flash size and bonded debugger pin pairs
	parameter bit LARGE_FLASH = 1'b0,
	parameter bit PAIR_FOUR   = 1'b1
) (
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic                       hresp,
	output logic [31:0]                hrdata,
	// Nonvolatile configuration storage
	input  wire logic [31:0]           nv_word0,
	input  wire logic [31:0]           nv_word1,
	// Flash protection
	input  wire logic [CWD_ADDR_W-1:0] prog_write_addr,
	output logic                       config_loaded,
	output logic                       ext_prog_access_allow,
	output logic                       boot_write_allow,
	output logic                       prog_write_blocked,
	output logic [CWD_ADDR_W-1:0]      prog_protect_limit,
	output logic                       prog_protect_all,
	// Debug
	output logic                       debug_pin_pair_one,
	output logic                       debug_pin_pair_two,
	output logic                       debug_pin_pair_three,
	output logic                       debug_pin_pair_four,
	output logic                       boundary_scan_enable,
	output logic                       debugger_enable,
	// Watchdog
	output logic [2:0]                 watchdog_window_eighths,
	output logic                       watchdog_run,
	output logic                       watchdog_window_mode,
	output logic [4:0]                 watchdog_postscale_exp,
	output logic [20:0]                watchdog_postscale_ratio,
	// Clocking
	output logic [2:0]                 oscillator_select,
	output logic                       primary_osc_enable,
	output logic [1:0]                 primary_osc_mode,
	output logic [3:0]                 peripheral_bus_divisor,
	output logic                       clock_switch_enable,
	output logic                       fail_safe_monitor_enable,
	output logic                       osc_cfg_conflict
);

	// State held by the block; everything else is decode
	logic [31:0] cfg0_q;      // Captured protection/debug word
	logic [31:0] cfg1_q;      // Captured watchdog/clock word
	logic        loaded_q;    // Words captured since reset
	logic        bse_q;       // Runtime boundary-scan enable
	logic        wdt_sw_q;    // Software watchdog enable
	logic        wr_pend_q;   // Write data phase pending
	logic [7:0]  wr_ofs_q;    // Offset of pending write
	logic [31:0] rdata_q;     // Read data for the data phase

	// Address phase decode. Only the low byte of the address is
	// decoded, so the register set repeats through the slave's range;
	// the bus fabric is expected to narrow hsel to a small window.
	wire         acc_valid = hsel & htrans[1] & hready;
	wire [7:0]   acc_ofs   = haddr[7:0];
	wire         hit_cfg0  = acc_ofs == CWD_OFS_CFG0;
	wire         hit_cfg1  = acc_ofs == CWD_OFS_CFG1;
	wire         hit_ctrl  = acc_ofs == CWD_OFS_CTRL;
	wire         hit_stat  = acc_ofs == CWD_OFS_STAT;
	wire         rd_go     = acc_valid & ~hwrite;
	wire         wr_go     = acc_valid & hwrite;
	// Only the control offset accepts write data
	wire         ctrl_wr   = wr_pend_q & (wr_ofs_q == CWD_OFS_CTRL);

	// Field extraction from the captured copies, never from the
	// storage pins, so a disturbance on storage after load cannot
	// move a decode
	wire         cp_bit    = cfg0_q[CWD_CP_BIT];
	wire         bwp_bit   = cfg0_q[CWD_BWP_BIT];
	wire [8:0]   pwp_raw   = cfg0_q[CWD_PWP_HI:CWD_PWP_LO];
	wire [1:0]   dps       = cfg0_q[CWD_DPS_HI:CWD_DPS_LO];
	wire [1:0]   dbg_raw   = cfg0_q[CWD_DBG_HI:CWD_DBG_LO];
	wire [1:0]   wws       = cfg1_q[CWD_WWS_HI:CWD_WWS_LO];
	wire         wfe       = cfg1_q[CWD_WFE_BIT];
	wire         wwd       = cfg1_q[CWD_WWD_BIT];
	wire [4:0]   wps_raw   = cfg1_q[CWD_WPS_HI:CWD_WPS_LO];
	wire [1:0]   csm       = cfg1_q[CWD_CSM_HI:CWD_CSM_LO];
	wire [1:0]   pbd       = cfg1_q[CWD_PBD_HI:CWD_PBD_LO];
	wire [1:0]   pom       = cfg1_q[CWD_POM_HI:CWD_POM_LO];
	wire [2:0]   osc       = cfg1_q[CWD_OSC_HI:CWD_OSC_LO];

	// Protection is active while the bit is programmed low
	// An erased part therefore comes up unprotected
	wire         cp_active = ~cp_bit;

	// Smaller parts have no top two protect bits; they act erased,
	// so a small part can never be set to protect all of memory
	wire [1:0]   pwp_top   = LARGE_FLASH ? pwp_raw[8:7] : CWD_PWP_TOP1;
	wire [8:0]   pwp_eff   = {pwp_top, pwp_raw[6:0]};
	// Protected page count is the distance from all ones. Pages are
	// 0x400 bytes, so the limit is the count above ten zero bits and
	// no multiplier is needed
	wire [8:0]   pwp_pages = CWD_PWP_NONE - pwp_eff;
	wire [CWD_ADDR_W-1:0] pwp_limit = {pwp_pages, CWD_PAGE_LOW};
	wire         pwp_all   = pwp_eff == CWD_PWP_ALL;

	// Debug field is overridden to the off code under protection
	// The raw field still reads back through the word register
	wire [1:0]   dbg_eff   = cp_active ? CWD_DBG_OFF : dbg_raw;

	// Postscale saturates at the largest listed setting
	// Codes above it are legal in storage, so clamp rather than flag
	wire         wps_over  = wps_raw > CWD_WPS_MAX;
	wire [4:0]   wps_eff   = wps_over ? CWD_WPS_MAX : wps_raw;

	// Primary source chosen while the primary oscillator is off
	// Only flagged: the reset source is still taken as programmed
	wire         osc_pri   = (osc == CWD_OSC_PRI) | (osc == CWD_OSC_PRI_PLL);
	wire         pom_off   = pom == CWD_POM_OFF;

	// Control reads back the effective watchdog state, not the
	// software bit, so software sees a forced watchdog as running
	wire [31:0]  ctrl_view = {28'h0000000, bse_q, 2'h0, watchdog_run};
	// Status: clock conflict, watchdog running, protection, loaded
	wire [31:0]  stat_view = {28'h0000000,
		osc_cfg_conflict,
		watchdog_run,
		cp_active,
		loaded_q};
	// Read mux; unmapped offsets read as zero so that software can
	// probe for the register set without a bus error
	wire [31:0]  rd_mux    = hit_cfg0 ? cfg0_q :
		hit_cfg1 ? cfg1_q :
		hit_ctrl ? ctrl_view :
		hit_stat ? stat_view : CWD_ZERO;

	// Window size code to eighths of the timeout period
	// Eighths keep all four sizes exact in three bits
	always_comb begin
		case (wws)
			2'h3:    watchdog_window_eighths = CWD_WIN_25;
			2'h2:    watchdog_window_eighths = CWD_WIN_375;
			2'h1:    watchdog_window_eighths = CWD_WIN_50;
			default: watchdog_window_eighths = CWD_WIN_75;
		endcase
	end

	// Capture both words once, on the first edge after release.
	// Reset itself loads only the erased constants, never the ports.
	// Until then the outputs decode as an erased, unprotected part, except boundary_scan_enable, which reset holds low.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg0_q   <= CWD_CFG0_ERASED;
			cfg1_q   <= CWD_CFG1_ERASED;
			loaded_q <= 1'b0;
		end else if (!loaded_q) begin
			cfg0_q   <= nv_word0;
			cfg1_q   <= nv_word1;
			loaded_q <= 1'b1;
		end
	end

	// Runtime boundary-scan bit: seeded at load, software may change it
	// Load wins over a write: none can be pending on the load edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bse_q <= 1'b0;
		end else if (!loaded_q) begin
			bse_q <= nv_word0[CWD_BSE_BIT];
		end else if (ctrl_wr) begin
			bse_q <= hwdata[CWD_CTRL_BSE];
		end
	end

	// Software watchdog enable; clearing it cannot stop a forced dog
	// The forced bit lives in the word, so no register can undo it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdt_sw_q <= 1'b0;
		end else if (ctrl_wr) begin
			wdt_sw_q <= hwdata[CWD_CTRL_WDT];
		end
	end

	// Remember a write address phase for its data phase
	// Writes land at the end of the data phase, while hwdata stands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_ofs_q  <= CWD_OFS_CFG0;
		end else if (hready) begin
			wr_pend_q <= wr_go;
			wr_ofs_q  <= acc_ofs;
		end
	end

	// Read data registered at the address phase, zero-wait answer.
	// Config words ignore writes: only the programmer alters them.
	// A write never disturbs hrdata, which holds the last read.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= CWD_ZERO;
		end else if (rd_go) begin
			rdata_q <= rd_mux;
		end
	end

	// Bus answer: never stalls, always OKAY
	// Registering the read mux in the address phase costs no wait
	// state and keeps hrdata free of decode glitches
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;

	// Flash protection outputs
	// Both access bits are active high: a programmed zero protects
	assign config_loaded         = loaded_q;
	assign ext_prog_access_allow = cp_bit;
	assign boot_write_allow      = bwp_bit;
	assign prog_protect_limit    = pwp_limit;
	assign prog_protect_all      = pwp_all;
	// All ones gives a zero limit, so nothing is blocked,
	// and all zeros blocks every address whatever the limit says
	assign prog_write_blocked    = pwp_all |
		(prog_write_addr < pwp_limit);

	// Debug pin pair n answers to code 4 - n, so pair one takes 11.
	// Exactly one pair is selected for any code, none for code 00 while PAIR_FOUR is clear.
	localparam int PAIRS = 4;  // Debugger pin pairs
	wire [PAIRS-1:0] pair_hit; // Bit n selects pair n + 1
	for (genvar g = 0; g < PAIRS; g++) begin : g_pair
		assign pair_hit[g] = dps == 2'(PAIRS - 1 - g);
	end
	// Pair four stays dark where the part does not bond it out
	assign debug_pin_pair_one    = pair_hit[0];
	assign debug_pin_pair_two    = pair_hit[1];
	assign debug_pin_pair_three  = pair_hit[2];
	assign debug_pin_pair_four   = PAIR_FOUR & pair_hit[3];
	assign boundary_scan_enable  = bse_q;
	// Only the 0x codes enable; 10 is treated as off,
	// which is the safe reading of a code the field does not list
	assign debugger_enable       = ~dbg_eff[1];

	// Watchdog outputs
	// The ratio is handed on as a count to spare the timer a decoder
	assign watchdog_run             = wfe | wdt_sw_q;
	assign watchdog_window_mode     = ~wwd;
	assign watchdog_postscale_exp   = wps_eff;
	assign watchdog_postscale_ratio = CWD_WPS_ONE << wps_eff;

	// Clocking outputs
	// Clock fields only take effect at reset; no live switching here
	assign oscillator_select        = osc;
	assign primary_osc_enable       = ~pom_off;
	assign primary_osc_mode         = pom;
	assign peripheral_bus_divisor   = CWD_PBD_ONE << pbd;
	assign clock_switch_enable      = ~csm[1];
	assign fail_safe_monitor_enable = csm == CWD_CSM_BOTH;
	// Flags a configuration the programmer should have avoided
	// The block still starts as programmed; software may report it
	assign osc_cfg_conflict         = osc_pri & pom_off;

	// Bus inputs the block does not decode, gathered in one sink so
	// that every input but htrans[0] is read; hsize is ignored, word access assumed
	wire unused_ok = &{1'b0, hsize, haddr[31:8], hwdata[31:4], hwdata[2:1]};

endmodule

// ---- test/cwd_nv_store.sv ----
/*
 Model of the programmer that burns both configuration words.
 Assumes the bench hands it raw words and changes them only in reset.
*/
module cwd_nv_store (
	input  wire logic [31:0] raw0,      // Word 0 as the user asked
	input  wire logic [31:0] raw1,      // Word 1 as the user asked
	input  wire logic        let_clash, // Bench lets a source clash through
	output logic      [31:0] nv_word0,
	output logic      [31:0] nv_word1
);
	timeunit 1ns;
	timeprecision 1ns;
	logic clash; // Primary source picked while primary is off

	// Reserved bits burnt as required: bit 31 of word 0 low, the rest high
	assign nv_word0 = (raw0 & 32'h1107_FC1F) | 32'h6EF8_03E0;
	assign clash = (raw1[2:1] == 2'h1) && (raw1[9:8] == 2'h3);
	// A careful programmer moves the mode from off to crystal on a clash
	assign nv_word1 = ((raw1 & 32'h03DF_F7A7) | 32'hFC20_0858)
		& ~{23'h0, clash & ~let_clash, 8'h0};
endmodule

// ---- test/cwd_config_word_decoder_asserts.sv ----
/*
 Port checks of the decoder, bound into every instance.
 Assumes the stored words stay still while out of reset.
*/
module cwd_decoder_chk #(
	parameter bit LARGE_FLASH = 1'b0
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic [31:0] nv_word0,
	input wire logic [31:0] nv_word1,
	input wire logic [18:0] prog_write_addr,
	input wire logic        config_loaded,
	input wire logic        prog_write_blocked,
	input wire logic [18:0] prog_protect_limit,
	input wire logic        prog_protect_all,
	input wire logic        debug_pin_pair_one,
	input wire logic        debug_pin_pair_four,
	input wire logic        boundary_scan_enable,
	input wire logic        debugger_enable,
	input wire logic [2:0]  watchdog_window_eighths,
	input wire logic        watchdog_run,
	input wire logic [4:0]  watchdog_postscale_exp
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [8:0] pwp; // Field with unfitted top bits read as ones
	logic       rd0; // Read of word 0 taken this edge

	assign pwp = LARGE_FLASH ? nv_word0[18:10] : {2'h3, nv_word0[16:10]};
	assign rd0 = hsel && htrans[1] && hready && !hwrite && (haddr[7:0] == 8'h00);

	a_pwp_limit: assert property (config_loaded |-> prog_protect_limit == {9'h1FF - pwp, 10'h000}
		&& prog_protect_all == (pwp == 9'h000)) else $error("protect limit wrong");
	a_pwp_block: assert property (config_loaded |-> prog_write_blocked == (pwp == 9'h000
		|| prog_write_addr < {9'h1FF - pwp, 10'h000})) else $error("block wrong");
	a_pair_sel: assert property (config_loaded |-> debug_pin_pair_one == (nv_word0[4:3] == 2'h3)
		&& debug_pin_pair_four == (nv_word0[4:3] == 2'h0)) else $error("pair wrong");
	a_bse_seed: assert property ($rose(config_loaded) |-> boundary_scan_enable == nv_word0[2])
		else $error("scan seed wrong");
	a_dbg_force: assert property (config_loaded |-> debugger_enable == (nv_word0[28]
		&& !nv_word0[1])) else $error("debugger wrong");
	a_win_size: assert property (config_loaded |-> watchdog_window_eighths == (nv_word1[25]
		? (nv_word1[24] ? 3'h2 : 3'h3) : (nv_word1[24] ? 3'h4 : 3'h6)))
		else $error("window wrong");
	a_wdt_force: assert property (config_loaded && nv_word1[23] |-> watchdog_run [*3])
		else $error("watchdog stopped");
	a_ps_clamp: assert property (config_loaded |-> watchdog_postscale_exp == ((nv_word1[20:16]
		> 5'h14) ? 5'h14 : nv_word1[20:16])) else $error("postscale wrong");
	a_rd_word: assert property (rd0 && config_loaded |=> hrdata == nv_word0)
		else $error("word read wrong");
endmodule

bind cwd_config_word_decoder cwd_decoder_chk #(.LARGE_FLASH(LARGE_FLASH)) chk_i (.*);

// ---- test/tb_config_word_decoder.sv ----
/*
 Self-checking bench of the decoder, built with the large flash option.
 Assumes it is the sole bus master; storage comes from the programmer model.
*/
module tb_config_word_decoder import cwd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		logic [31:0] w0, w1; // Words as programmed
		logic [18:0] lim;    // Protect boundary
		logic        dbg;    // Debugger on
		logic [2:0]  win;    // Window in eighths
		logic [4:0]  ex;     // Postscale exponent
		logic [3:0]  div;    // Peripheral divisor
	} cwd_row_t;
	cwd_row_t rows [4] = '{'{32'h7FFF_FFFF, 32'hFFFF_FFFF, 19'h0, 0, 3'h2, 5'h14, 4'h8},
		'{32'h6FFF_FBF0, 32'hFC34_0858, 19'h00400, 0, 3'h6, 5'h14, 4'h1},
		'{32'h7FFB_FFED, 32'hFDEA_5A5C, 19'h40000, 1, 3'h4, 5'h0A, 4'h2},
		'{32'h7EF8_03E2, 32'hFE37_AB5B, 19'h7FC00, 0, 3'h3, 5'h14, 4'h4}};
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, let_clash;
	logic        config_loaded, ext_prog_access_allow, boot_write_allow, prog_protect_all;
	logic        prog_write_blocked, boundary_scan_enable, debugger_enable, watchdog_run;
	logic        debug_pin_pair_one, debug_pin_pair_two, debug_pin_pair_three;
	logic        debug_pin_pair_four, watchdog_window_mode, primary_osc_enable;
	logic        clock_switch_enable, fail_safe_monitor_enable, osc_cfg_conflict;
	logic [1:0]  htrans, primary_osc_mode;
	logic [2:0]  hsize, watchdog_window_eighths, oscillator_select;
	logic [3:0]  peripheral_bus_divisor;
	logic [4:0]  watchdog_postscale_exp;
	logic [18:0] prog_write_addr, prog_protect_limit;
	logic [20:0] watchdog_postscale_ratio;
	logic [31:0] haddr, hwdata, hrdata, raw0, raw1, nv_word0, nv_word1, rd;
	wire logic   hready;          // Sole slave drives the bus ready
	int          n_errors, num_checks, cycles;

	assign hready = hreadyout;
	cwd_config_word_decoder #(.LARGE_FLASH(1'b1)) cwd_config_word_decoder_i (.*);
	cwd_nv_store cwd_nv_store_i (.*);

	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	// Hang guard: far above the under two hundred cycles the run needs
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			close_out();
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One single word transfer; waits on ready rather than a fixed count
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("resp", 32'h0, hresp);
		chk("ready", 32'h1, hreadyout);
	endtask

	// Words change only under reset, as storage is read at release
	task automatic boot(input logic [31:0] a, input logic [31:0] b, input logic c);
		@(posedge hclk);
		hresetn <= 1'b0;
		raw0 <= a;
		raw1 <= b;
		let_clash <= c;
		repeat (12) @(posedge hclk);
		chk("loaded_rst", 32'h0, config_loaded);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
	endtask

	task automatic probe(input logic [18:0] a, input logic exp);
		@(posedge hclk);
		prog_write_addr <= a;
		@(negedge hclk);
		chk("blocked", exp, prog_write_blocked);
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		cwd_row_t r; // Row under test
		{hresetn, hsel, hwrite, let_clash, htrans, haddr, hwdata} = '0;
		{raw0, raw1, prog_write_addr} = '0;
		hsize = 3'h2;
		for (int i = 0; i < 4; i++) begin
			r = rows[i];
			boot(r.w0, r.w1, i == 3);
			chk("scan_seed", r.w0[2], boundary_scan_enable);
			ahb(1'b0, CWD_OFS_CFG0, 32'h0);
			chk("word0", r.w0, rd);
			ahb(1'b0, CWD_OFS_CFG1, 32'h0);
			chk("word1", r.w1, rd);
			ahb(1'b1, CWD_OFS_CTRL, 32'h0);
			@(negedge hclk);
			chk("wdt_run", r.w1[23], watchdog_run);
			chk("cp", r.w0[28], ext_prog_access_allow);
			chk("bwp", r.w0[24], boot_write_allow);
			chk("limit", r.lim, prog_protect_limit);
			chk("all", i == 3, prog_protect_all);
			chk("pairs", 4'h1 << r.w0[4:3], {debug_pin_pair_one, debug_pin_pair_two,
				debug_pin_pair_three, debug_pin_pair_four});
			chk("dbg", r.dbg, debugger_enable);
			chk("win", r.win, watchdog_window_eighths);
			chk("wmode", !r.w1[22], watchdog_window_mode);
			chk("ps", r.ex, watchdog_postscale_exp);
			chk("ratio", 32'h1 << r.ex, watchdog_postscale_ratio);
			chk("osc", r.w1[2:0], oscillator_select);
			chk("pmode", r.w1[9:8], primary_osc_mode);
			chk("div", r.div, peripheral_bus_divisor);
			chk("fsm", r.w1[15:14] == 2'h0, fail_safe_monitor_enable);
			chk("posc_en", r.w1[9:8] != 2'h3, primary_osc_enable);
			chk("csw_en", !r.w1[15], clock_switch_enable);
			chk("loaded", 32'h1, config_loaded);
			chk("clash", i == 3, osc_cfg_conflict);
			probe(r.lim, i == 3);
			probe(r.lim - 19'h1, r.lim != 19'h0);
			$display("row %0d done", i);
		end
		// Software side: control write, status, read-only word, hole
		boot(rows[1].w0, rows[1].w1, 1'b0);
		ahb(1'b1, CWD_OFS_CTRL, 32'h0000_0009);
		ahb(1'b0, CWD_OFS_CTRL, 32'h0);
		chk("ctrl", 32'h0000_0009, rd);
		ahb(1'b0, CWD_OFS_STAT, 32'h0);
		chk("stat", 32'h0000_0007, rd);
		ahb(1'b1, CWD_OFS_CFG0, 32'h0);
		ahb(1'b0, CWD_OFS_CFG0, 32'h0);
		chk("ro_word0", rows[1].w0, rd);
		ahb(1'b0, 8'h10, 32'h0);
		chk("hole", 32'h0, rd);
		// Careful programmer turns a clash into a running crystal
		boot(rows[3].w0, rows[3].w1, 1'b0);
		ahb(1'b0, CWD_OFS_CFG1, 32'h0);
		chk("fixed_word1", 32'hFE37_AA5B, rd);
		chk("no_clash", 32'h0, osc_cfg_conflict);
		$display("register tests done");
		close_out();
	end
endmodule
